/* common/rpm_pkg.sv */
/*
 * Shared constants and types for the reset and port pin multiplexer.
 * Assumes one core clock, and a power-on reset that is asynchronous and active low.
 */
package rpm_pkg;

  // ****************************************************************
  // Sizes and release timing
  // ****************************************************************
  localparam int unsigned PORT_BITS      = 4;   // Port A bits 0 to 3
  localparam int unsigned RELEASE_CYCLES = 32;  // Core clocks from request end to release, at least 2

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [3:0] SEL_PRIMARY   = 4'h0;  // All four pins on port function
  localparam logic       A7_RESET_MODE = 1'h0;  // Shared pin acts as the reset input
  localparam logic [3:0] PULL_RESET    = 4'hF;  // Pull-ups on while in reset
  localparam logic [3:0] OE_RESET      = 4'h0;  // No pin driven while in reset

  // ****************************************************************
  // Reset release sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    RR_HOLD  = 3'h1,  // Request present, core held in reset
    RR_COUNT = 3'h2,  // Request gone, counting up to release
    RR_RUN   = 3'h4   // Core released
  } rpm_rel_e;

endpackage

/* logic/rpm_reset_release.sv */
/*
 * Reset release sequencer: holds the core reset while any request stands,
 * then releases it on a clock edge after a fixed count of core clocks.
 * Assumes the request is already synchronous to clk_in.
 */
`timescale 1ns/100ps
module rpm_reset_release
  import rpm_pkg::*;
#(
  parameter int unsigned CYCLES = RELEASE_CYCLES  // Clocks of quiet request before release
) (
  // Clock and power-on reset
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  // Combined reset request
  input  wire logic req_in,
  // Core reset, active low
  output logic      core_rst_b_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  localparam int unsigned     CW   = $clog2(CYCLES + 1);
  localparam logic [CW-1:0]   LAST = CW'(CYCLES - 1);
  localparam logic [CW-1:0]   ONE  = CW'(1);

  typedef struct packed {
    rpm_rel_e        state;   // Sequencer state
    logic [CW-1:0]   cnt;     // Quiet clocks seen so far
    logic            core_b;  // Registered core reset, active low
  } rpm_rel_s;

  rpm_rel_s st;       // Current state
  rpm_rel_s next_st;  // Next state

  // Next state: any request wins over counting and over run
  always_comb begin
    next_st = st;
    unique case (st.state)
      RR_HOLD: begin
        if (!req_in) begin
          next_st.state = RR_COUNT;
          next_st.cnt   = ONE;
        end
      end
      RR_COUNT: begin
        if (req_in) begin
          next_st.state = RR_HOLD;
        end else if (st.cnt == LAST) begin
          next_st.state  = RR_RUN;
          next_st.core_b = 1'h1;
        end else begin
          next_st.cnt = st.cnt + ONE;
        end
      end
      RR_RUN: begin
        if (req_in) begin
          next_st.state  = RR_HOLD;
          next_st.core_b = 1'h0;
        end
      end
      default: begin
        next_st.state  = RR_HOLD;  // Illegal code falls back to reset
        next_st.core_b = 1'h0;
      end
    endcase
    if (next_st.state == RR_HOLD) begin
      next_st.cnt = '0;
    end
  end

  // State register; power-on reset leaves the core held
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '{state: RR_HOLD, cnt: '0, core_b: 1'h0};
    end else begin
      st <= next_st;
    end
  end

  assign core_rst_b_out = st.core_b;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  logic [CW-1:0] quiet;  // Helper: consecutive clocks without request, saturating
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      quiet <= '0;
    end else if (req_in) begin
      quiet <= '0;
    end else if (quiet != LAST + ONE) begin
      quiet <= quiet + ONE;
    end
  end

  a_hold_on_req: assert property (req_in |=> !core_rst_b_out)
    else $error("core reset not held while request present");
  a_release_count: assert property ($rose(core_rst_b_out) |-> quiet == LAST + ONE)
    else $error("core reset released after wrong clock count");
  a_release_done: assert property ((quiet == LAST + ONE) |-> core_rst_b_out)
    else $error("core reset not released after the fixed count");
  c_release: cover property ($rose(core_rst_b_out));

endmodule

/* logic/rpm_pin_mux.sv */
/*
 * Pin multiplexer for the shared reset pin (port A bit 7) and port A bits 0 to 3,
 * with the reset release logic behind it.
 * Assumes all pin levels and control inputs are synchronous to clk_in, that the
 * system integration control presents selections with a one-cycle load strobe,
 * and that the pad ring resolves out, enable and pull-up into the wire level.
 */

// Behaviour
// - Pins leave reset on primary function.
// - Reset pin low holds whole device reset.
// - Release core reset synchronously after fixed count.
// - Bit 7 port mode: input or open drain.
// - Port mode pin cannot reset; others can.
// - Each port bit direction set independently.
// - Alternate function drives pulse channels 0-3 out.
// - Selection comes from system integration control.

`timescale 1ns/100ps
module rpm_pin_mux
  import rpm_pkg::*;
#(
  parameter int unsigned BITS   = PORT_BITS,      // Number of pulse-capable port bits
  parameter int unsigned CYCLES = RELEASE_CYCLES  // Reset release count
) (
  // Clock and power-on reset
  input  wire logic            clk_in,
  input  wire logic            rst_b_in,
  // Other reset sources
  input  wire logic            watchdog_reset_in,
  input  wire logic            soft_reset_in,
  // System integration control selections
  input  wire logic            sic_load_in,
  input  wire logic [BITS-1:0] sic_alt_sel_in,
  input  wire logic            sic_a7_gpio_in,
  // Port settings from the port block
  input  wire logic [BITS-1:0] gpio_dir_in,
  input  wire logic [BITS-1:0] gpio_data_in,
  input  wire logic [BITS:0]   gpio_pull_in,
  input  wire logic            a7_dir_in,
  input  wire logic            a7_data_in,
  // Pulse peripheral channels
  input  wire logic [BITS-1:0] pulse_out_ch_in,
  // Port A bits 0 to 3 pads
  input  wire logic [BITS-1:0] port_a_bit_pin_in,
  output logic      [BITS-1:0] port_a_bit_pin_out,
  output logic      [BITS-1:0] port_a_bit_pin_oe_out,
  output logic      [BITS-1:0] port_a_bit_pin_pu_out,
  // Shared reset pin, port A bit 7 pad
  input  wire logic            port_a_bit7_pin_in,
  output logic                 port_a_bit7_pin_out,
  output logic                 port_a_bit7_pin_oe_out,
  output logic                 port_a_bit7_pin_pu_out,
  // Read-back and status
  output logic      [BITS:0]   gpio_read_out,
  output logic      [BITS-1:0] alt_sel_out,
  output logic                 a7_gpio_out,
  output logic                 core_rst_b_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [BITS-1:0] alt_sel;  // One bit per pin, set selects the pulse channel
    logic            a7_gpio;  // Set turns the reset pin into port A bit 7
    logic [BITS-1:0] pin_out;  // Registered pad data
    logic [BITS-1:0] pin_oe;   // Registered pad enables
    logic [BITS-1:0] pin_pu;   // Registered pull-up enables
    logic            a7_oe;    // Bit 7 pulls low when set
    logic            a7_pu;    // Bit 7 pull-up
    logic [BITS:0]   rd;       // Registered pad levels for read-back
  } rpm_mux_s;

  // One packed register holds every piece of mux state, the release sequencer keeps its own; next_st is its next value
  rpm_mux_s st;       // Current state
  rpm_mux_s next_st;  // Next state
  logic     pin_req;  // Reset pin asserting a reset
  logic     req;      // Any reset source
  logic     core_b;   // Core reset, active low

  // Pad drive for one pin: returns {enable, data}
  function automatic logic [1:0] drive_sel(input logic alt, input logic pulse,
                                           input logic dir, input logic data);
    logic [1:0] r;
    r = '0;
    if (alt) begin
      // Channel owns the pad: always driven, port data and direction ignored
      r = {1'h1, pulse};
    end else begin
      // Port function: direction and data straight from the port block
      r = {dir, data};
    end
    return r;
  endfunction

  // ****************************************************************
  // Reset sources
  // ****************************************************************
  // Level sensitive: a held button keeps the core in reset for as long as it is held
  // Pin only counts as reset while it is in reset mode; the other sources always count
  assign pin_req = !st.a7_gpio && !port_a_bit7_pin_in;
  assign req     = pin_req || watchdog_reset_in || soft_reset_in;

  // Release sequencer; a reset request also clears the selections through core_b
  rpm_reset_release #(
    .CYCLES(CYCLES)
  ) rpm_reset_release_inst (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .req_in        (req),
    .core_rst_b_out(core_b)
  );

  // ****************************************************************
  // Selection and pad drive
  // ****************************************************************
  // Drive is derived from the registered selection, so a new selection reaches
  // the pads one clock after its load; this keeps every pad output glitch free.
  always_comb begin
    next_st    = st;
    // Pad levels are captured every cycle, in reset too
    next_st.rd = {port_a_bit7_pin_in, port_a_bit_pin_in};
    if (!core_b) begin
      // Core reset: clear every selection and park every pad as an input
      next_st.alt_sel = SEL_PRIMARY;
      next_st.a7_gpio = A7_RESET_MODE;
      next_st.pin_oe  = OE_RESET;
      next_st.pin_out = '0;
      next_st.pin_pu  = PULL_RESET;
      next_st.a7_oe   = 1'h0;
      next_st.a7_pu   = 1'h1;
    end else begin
      // Only an explicit load from the integration control changes a selection
      if (sic_load_in) begin
        next_st.alt_sel = sic_alt_sel_in;
        next_st.a7_gpio = sic_a7_gpio_in;
      end
      // Each bit decoded on its own so no pin disturbs a neighbour
      for (int i = 0; i < BITS; i++) begin
        {next_st.pin_oe[i], next_st.pin_out[i]} =
          drive_sel(st.alt_sel[i], pulse_out_ch_in[i], gpio_dir_in[i], gpio_data_in[i]);
        next_st.pin_pu[i] = !st.alt_sel[i] && !gpio_dir_in[i] && gpio_pull_in[i];
      end
      // Bit 7 never drives high: a zero pulls low, a one releases the wire
      next_st.a7_oe = st.a7_gpio && a7_dir_in && !a7_data_in;
      // In reset mode the pin is the reset input and keeps its pull-up
      next_st.a7_pu = !st.a7_gpio || gpio_pull_in[BITS];
    end
  end

  // State register; power-on leaves every pad an input with pull-up
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '{alt_sel: SEL_PRIMARY, a7_gpio: A7_RESET_MODE, pin_out: '0, pin_oe: OE_RESET,
              pin_pu: PULL_RESET, a7_oe: 1'h0, a7_pu: 1'h1, rd: '0};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every pad output but the constant bit 7 data comes straight from a flip-flop, so none can glitch
  assign port_a_bit_pin_out     = st.pin_out;
  assign port_a_bit_pin_oe_out  = st.pin_oe;
  assign port_a_bit_pin_pu_out  = st.pin_pu;
  assign port_a_bit7_pin_out    = 1'h0;  // Open drain: data is always low
  assign port_a_bit7_pin_oe_out = st.a7_oe;
  assign port_a_bit7_pin_pu_out = st.a7_pu;
  assign gpio_read_out          = st.rd;
  assign alt_sel_out            = st.alt_sel;
  assign a7_gpio_out            = st.a7_gpio;
  assign core_rst_b_out         = core_b;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // Selection: primary after reset, changed only by a load
  a_primary_after_rst: assert property (!core_b |=> st.alt_sel == SEL_PRIMARY && !st.a7_gpio)
    else $error("selection not primary after reset");
  a_alt_needs_load: assert property ((st.alt_sel != $past(st.alt_sel) && $past(core_b)) |-> $past(sic_load_in))
    else $error("selection changed without load");
  a_sel_from_sic: assert property ((core_b && sic_load_in) |=>
      st.alt_sel == $past(sic_alt_sel_in) && st.a7_gpio == $past(sic_a7_gpio_in))
    else $error("selection does not follow integration control");

  // Reset sources and reset-time pad state
  a_pin_holds_rst: assert property (pin_req |=> !core_b)
    else $error("reset pin low did not hold reset");
  a_a7_open_drain: assert property (port_a_bit7_pin_oe_out |->
      !port_a_bit7_pin_out && $past(st.a7_gpio && a7_dir_in && !a7_data_in))
    else $error("bit 7 driven other than open drain");
  a_gpio_pin_quiet: assert property ((st.a7_gpio && core_b && !watchdog_reset_in && !soft_reset_in)
      |=> core_b)
    else $error("port mode pin level caused a reset");
  a_rst_pullups: assert property (!core_b |=> port_a_bit_pin_oe_out == OE_RESET &&
      port_a_bit_pin_pu_out == PULL_RESET && !port_a_bit7_pin_oe_out && port_a_bit7_pin_pu_out)
    else $error("pins not inputs with pull-up in reset");
  a_a7_rst_input: assert property (!st.a7_gpio |=> !port_a_bit7_pin_oe_out && port_a_bit7_pin_pu_out)
    else $error("reset pin not an input with pull-up");

  // Pad drive, one bit at a time
  a_gpio_dir_each: assert property (core_b |=>
      (port_a_bit_pin_oe_out & ~$past(st.alt_sel)) == ($past(gpio_dir_in) & ~$past(st.alt_sel)))
    else $error("port direction not per bit");
  a_alt_pulse_out: assert property (core_b |=>
      (port_a_bit_pin_out & $past(st.alt_sel)) == ($past(pulse_out_ch_in) & $past(st.alt_sel)))
    else $error("alternate pin does not carry pulse channel");
  a_alt_overrides: assert property (core_b |=>
      (port_a_bit_pin_oe_out & $past(st.alt_sel)) == $past(st.alt_sel))
    else $error("peripheral did not override direction");

  // Main scenarios: alternate drive, open-drain pull, resets in both pin modes
  c_alt_active: cover property (core_b && st.alt_sel != SEL_PRIMARY ##1 |port_a_bit_pin_out);
  c_a7_pull_low: cover property (port_a_bit7_pin_oe_out);
  c_wdog_in_gpio: cover property (st.a7_gpio && watchdog_reset_in ##1 !core_b);
  c_pin_reset: cover property (pin_req && core_b ##1 !core_b);

endmodule

/* verif/rpm_board.sv */
/*
 * Board model: resolves the pads of port A bits 0 to 3 and the shared reset pin.
 * Assumes the bench supplies the external reset button and the weak board levels.
 */
`timescale 1ns/100ps
module rpm_board (
  // Core clock
  input  wire logic       clk_in,
  // Pad drive from the device
  input  wire logic [3:0] pad_out_in,
  input  wire logic [3:0] pad_oe_in,
  input  wire logic       bit7_oe_in,
  input  wire logic       bit7_pu_in,
  // Board stimulus
  input  wire logic       ext_rst_b_in,
  input  wire logic [3:0] ext_lvl_in,
  // Resolved levels
  output logic      [3:0] pin_lvl_out,
  output logic            bit7_lvl_out
);
  // ****************************************************************
  // Pin resolution
  // ****************************************************************
  logic flip;  // Floating pin pattern, so no stale level passes for a real one
  initial flip = 1'b0;
  always @(posedge clk_in) flip <= ~flip;
  // Weak board levels lose to any enabled pad driver
  always_comb begin
    pin_lvl_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & ext_lvl_in);
    // Open drain: only pulls low; otherwise pull-up or a floating pattern
    if (bit7_oe_in || !ext_rst_b_in) begin
      bit7_lvl_out = 1'b0;
    end else begin
      bit7_lvl_out = bit7_pu_in ? 1'b1 : flip;
    end
  end
endmodule

/* verif/tb_rpm_pin_mux.sv */
/*
 * Self-checking bench for the pin multiplexer with a short release count.
 * Assumes the board model resolves pin levels; expectations queue up by due cycle.
 */
`timescale 1ns/100ps
module tb_rpm_pin_mux;
  import rpm_pkg::*;
  localparam int CYC = 2;  // Short release count, the minimum allowed
  typedef struct {int due; int id; logic [11:0] exp;} rpm_note_s;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk_in, rst_b_in, wd, sr, ld, a7s, a7d, a7v, ext_rst_b, m_a7;
  logic [3:0]  asel, dir, dat, pulse, ext, pin_i, p_out, p_oe, p_pu, alt_o, m_alt;
  logic [4:0]  pull, rd;
  logic        p7_i, p7_out, p7_oe, p7_pu, a7g_o, core_b;
  logic [31:0] lf = 32'h00014B90;  // Random source start
  int          cyc, miscompares, compares;
  rpm_note_s   notes[$];  // Expected results, oldest first
  string       nm[6] = '{"pads", "select", "core_rst", "bit7", "read", "reset_pads"};

  rpm_pin_mux #(.CYCLES(CYC)) rpm_pin_mux_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .watchdog_reset_in(wd), .soft_reset_in(sr), .sic_load_in(ld), .sic_alt_sel_in(asel),
    .sic_a7_gpio_in(a7s), .gpio_dir_in(dir), .gpio_data_in(dat), .gpio_pull_in(pull),
    .a7_dir_in(a7d), .a7_data_in(a7v), .pulse_out_ch_in(pulse), .port_a_bit_pin_in(pin_i),
    .port_a_bit_pin_out(p_out), .port_a_bit_pin_oe_out(p_oe), .port_a_bit_pin_pu_out(p_pu),
    .port_a_bit7_pin_in(p7_i), .port_a_bit7_pin_out(p7_out), .port_a_bit7_pin_oe_out(p7_oe),
    .port_a_bit7_pin_pu_out(p7_pu), .gpio_read_out(rd), .alt_sel_out(alt_o),
    .a7_gpio_out(a7g_o), .core_rst_b_out(core_b));
  rpm_board rpm_board_inst (.clk_in(clk_in), .pad_out_in(p_out), .pad_oe_in(p_oe),
    .bit7_oe_in(p7_oe), .bit7_pu_in(p7_pu), .ext_rst_b_in(ext_rst_b), .ext_lvl_in(ext),
    .pin_lvl_out(pin_i), .bit7_lvl_out(p7_i));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) cyc <= cyc + 1;
  // Outputs grouped per check item
  function automatic logic [11:0] seen(int id);
    case (id)
      0: return {p_out, p_oe, p_pu};
      1: return {7'h00, a7g_o, alt_o};
      2: return {11'h000, core_b};
      3: return {9'h000, p7_out, p7_oe, p7_pu};
      4: return {7'h00, rd};
      default: return {4'h0, p_oe, p_pu};
    endcase
  endfunction
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  // Pad drive expected from the current inputs and the modelled selection
  function automatic logic [11:0] exp_pads();
    logic [11:0] e;
    for (int i = 0; i < 4; i++) begin
      e[8+i] = m_alt[i] ? pulse[i] : dat[i];
      e[4+i] = m_alt[i] | dir[i];
      e[i]   = ~m_alt[i] & ~dir[i] & pull[i];
    end
    return e;
  endfunction
  task automatic note(int id, logic [11:0] e, int d);
    notes.push_back('{cyc + d, id, e});
  endtask
  task automatic step(int n = 1);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  // Inputs have been held one edge, so pads have settled; read-back settles at the next
  task automatic chk();
    logic [11:0] e;
    e = exp_pads();
    note(0, e, 1);
    note(3, {10'h000, m_a7 & a7d & ~a7v, m_a7 ? pull[4] : 1'b1}, 1);
    note(4, {7'h00, ~(m_a7 & a7d & ~a7v), (e[7:4] & e[11:8]) | (~e[7:4] & ext)}, 1);
    step();
  endtask
  task automatic shake();
    logic [31:0] r;
    r = rnd();
    {dir, dat, pulse, ext} = r[15:0];
    pull = {1'b1, r[19:16]};  // Bit 7 pull kept on so its level is defined
    a7d = r[20];
    a7v = r[21];
    step();
    chk();
  endtask
  task automatic load(logic [3:0] s, logic g);
    asel = s;
    a7s = g;
    ld = 1'b1;
    step();
    ld = 1'b0;
    m_alt = s;
    m_a7 = g;
    note(1, {7'h00, g, s}, 0);
  endtask
  // One reset source: 0 pin, 1 watchdog, 2 software
  task automatic kick(int src);
    if (src == 0) ext_rst_b = 1'b0;
    else if (src == 1) wd = 1'b1;
    else sr = 1'b1;
    step();
    note(2, 12'h000, 0);
    note(1, 12'h000, 1);
    note(5, 12'h00F, 1);
    ext_rst_b = 1'b1;
    wd = 1'b0;
    sr = 1'b0;
    m_alt = 4'h0;
    m_a7 = 1'b0;
    note(2, 12'h000, CYC - 1);
    note(2, 12'h001, CYC);
    step(CYC + 1);
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Checker: takes the oldest note when its cycle comes
  // ****************************************************************
  always @(negedge clk_in) begin
    rpm_note_s n;
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      n = notes.pop_front();
      compares++;
      if (n.due != cyc || seen(n.id) !== n.exp) begin
        miscompares++;
        $display("[ERR] %s exp %h got %h", nm[n.id], n.exp, seen(n.id));
      end
    end
  end
  // Watchdog: the run needs about 70 cycles, the limit is 3000
  initial begin
    #(25 * 3000);
    miscompares++;
    wrap_up();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rst_b_in, wd, sr, ld, a7s, a7d, a7v, asel, dir, dat, pulse, ext} = '0;
    {ext_rst_b, pull, m_alt, m_a7} = {1'b1, 5'h1F, 4'h0, 1'b0};
    step(5);
    note(5, 12'h00F, 0);
    note(2, 12'h000, 0);
    rst_b_in = 1'b1;
    note(2, 12'h000, CYC - 1);
    note(2, 12'h001, CYC);
    step(CYC);
    note(1, 12'h000, 0);
    repeat (4) shake();
    load(4'h5, 1'b0);
    repeat (3) shake();
    load(4'hF, 1'b0);
    repeat (2) shake();
    load(4'h6, 1'b0);
    repeat (3) shake();
    kick(0);
    shake();
    load(4'h3, 1'b1);
    repeat (4) shake();
    a7d = 1'b1;
    a7v = 1'b0;
    pull[4] = 1'b0;
    step();
    chk();
    pull[4] = 1'b1;
    a7d = 1'b0;
    ext_rst_b = 1'b0;
    step(3);
    note(2, 12'h001, 0);
    ext_rst_b = 1'b1;
    step();
    kick(1);
    load(4'hC, 1'b1);
    kick(2);
    repeat (2) shake();
    step(2);
    wrap_up();
  end
endmodule
